// ==== rtl/mpsc_pkg.sv ====
package mpsc_pkg;
    // register offsets, as printed
    localparam logic [11:0] FIRST_CFG_OFS   = 12'h01E;
    localparam logic [11:0] SECOND_CFG_OFS  = 12'h01F;
    localparam logic [11:0] FIRST_WIDTH_OFS = 12'h020;
    localparam logic [11:0] FIRST_THR_OFS   = 12'h022;
    localparam logic [11:0] SECOND_WIDTH_OFS = 12'h026;
    localparam logic [11:0] SECOND_THR_OFS  = 12'h028;

    // reset values
    localparam logic [7:0]  CFG_RESET   = 8'h00;
    localparam logic [15:0] WIDTH_RESET = 16'h009C;
    localparam logic [31:0] THR_RESET   = 32'h0010_0000;

    // config field layout
    localparam int SEL_HI  = 7;
    localparam int SEL_LO  = 3;
    localparam int PHASE_C = 2;
    localparam int PHASE_B = 1;
    localparam int PHASE_A = 0;

    // widths
    localparam int VAL_W = 24;
    localparam int INC_W = 27;
    localparam int ACC_W = 40;

    // source select codes
    localparam logic [4:0] SRC_NET_REAL   = 5'h00;
    localparam logic [4:0] SRC_ABS_REAL   = 5'h01;
    localparam logic [4:0] SRC_NET_REACT  = 5'h02;
    localparam logic [4:0] SRC_ABS_REACT  = 5'h03;
    localparam logic [4:0] SRC_APPARENT   = 5'h04;
    localparam logic [4:0] SRC_IRMS       = 5'h06;
    localparam logic [4:0] SRC_VRMS       = 5'h07;
    localparam logic [4:0] SRC_REAL_LOAD  = 5'h08;
    localparam logic [4:0] SRC_REAL_LINE  = 5'h09;
    localparam logic [4:0] SRC_REACT_Q1   = 5'h0A;
    localparam logic [4:0] SRC_REACT_Q2   = 5'h0B;
    localparam logic [4:0] SRC_REACT_Q3   = 5'h0C;
    localparam logic [4:0] SRC_REACT_Q4   = 5'h0D;

    // pulse channel states
    typedef enum logic [1:0] {
        MPSC_IDLE   = 2'b01,
        MPSC_ACTIVE = 2'b10
    } mpsc_state_e;
endpackage

// ==== rtl/mpsc_pulse_chan.sv ====
`timescale 1ns/100ps
// one pulse output: accumulate per frame, fire on threshold, hold width
module mpsc_pulse_chan (
    input  wire logic                               ref_clk,
    input  wire logic                               rst,
    input  wire logic                               frame_tick,
    input  wire logic signed [mpsc_pkg::INC_W-1:0]  increment,
    input  wire logic [31:0]                        threshold,
    input  wire logic [15:0]                        pulse_width,
    output logic                                    pulse_out_r
);
    mpsc_pkg::mpsc_state_e            state_r, state_nxt;
    logic signed [mpsc_pkg::ACC_W-1:0] acc_r, acc_nxt;
    logic [15:0]                       cnt_r, cnt_nxt;
    logic                              pulse_nxt;
    logic signed [mpsc_pkg::ACC_W-1:0] sum;
    logic signed [mpsc_pkg::ACC_W-1:0] thr_ext;

    // next-state: accumulate once per frame, fire when sum exceeds threshold
    always_comb begin
        sum       = acc_r + mpsc_pkg::ACC_W'(increment);
        thr_ext   = mpsc_pkg::ACC_W'({1'b0, threshold});
        state_nxt = state_r;
        acc_nxt   = acc_r;
        cnt_nxt   = cnt_r;
        if (frame_tick) begin
            acc_nxt = sum;
            case (state_r)
                mpsc_pkg::MPSC_IDLE: begin
                    cnt_nxt = cnt_r;
                end
                mpsc_pkg::MPSC_ACTIVE: begin
                    // width counted in frames
                    if (cnt_r <= 16'h0001) begin
                        state_nxt = mpsc_pkg::MPSC_IDLE;
                        cnt_nxt   = 16'h0000;
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
                default: begin
                    state_nxt = mpsc_pkg::MPSC_IDLE;
                end
            endcase
            // a new crossing restarts the width; one during a pulse only stretches it, so a counter sees one pulse
            if (sum > thr_ext) begin
                acc_nxt = sum - thr_ext;
                if (pulse_width != 16'h0000) begin
                    state_nxt = mpsc_pkg::MPSC_ACTIVE;
                    cnt_nxt   = pulse_width;
                end
            end
        end
        pulse_nxt = (state_nxt == mpsc_pkg::MPSC_ACTIVE);
    end

    // state registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r     <= mpsc_pkg::MPSC_IDLE;
            acc_r       <= '0;
            cnt_r       <= 16'h0000;
            pulse_out_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            acc_r       <= acc_nxt;
            cnt_r       <= cnt_nxt;
            pulse_out_r <= pulse_nxt;
        end
    end
endmodule // mpsc_pulse_chan

// ==== rtl/mpsc_top.sv ====
`timescale 1ns/100ps
module mpsc_top (
    // one clock; rst is synchronous and active high
    input  wire logic                              ref_clk,
    input  wire logic                              rst,
    // register bus: one-cycle strobes, exact offset match
    input  wire logic [11:0]                       reg_addr,
    input  wire logic [31:0]                       reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic [31:0]                            reg_rdata_r,
    // converter frame pulse; phase values are taken with it
    input  wire logic                              frame_tick,
    // signed per-phase values, refreshed every frame
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_a_real,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_a_reactive,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_a_apparent,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_a_irms,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_a_vrms,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_b_real,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_b_reactive,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_b_apparent,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_b_irms,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_b_vrms,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_c_real,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_c_reactive,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_c_apparent,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_c_irms,
    input  wire logic signed [mpsc_pkg::VAL_W-1:0] phase_c_vrms,
    // pulse outputs, active high, one flop each in the channels
    output logic                                   first_pulse_output,
    output logic                                   second_pulse_output
);
    // short names keep the function headers inside the line limit
    localparam int VW = mpsc_pkg::VAL_W;
    localparam int IW = mpsc_pkg::INC_W;

    // index 0 serves the first output, index 1 the second
    logic [7:0]  cfg_r      [2];
    logic [7:0]  cfg_nxt    [2];
    logic [15:0] width_r    [2];
    logic [15:0] width_nxt  [2];
    logic [31:0] thr_r      [2];
    logic [31:0] thr_nxt    [2];
    // read data staged for the output register
    logic [31:0] rdata_nxt;
    // channel outputs, already registered
    logic        pulse_w    [2];

    // per-phase bundles so the channel loop can index by phase
    logic signed [VW-1:0] real_v  [3];
    logic signed [VW-1:0] react_v [3];
    logic signed [VW-1:0] appr_v  [3];
    logic signed [VW-1:0] irms_v  [3];
    logic signed [VW-1:0] vrms_v  [3];

    // phase A sits at index 0, matching config bit 0
    assign real_v  = '{phase_a_real, phase_b_real, phase_c_real};
    assign react_v = '{phase_a_reactive, phase_b_reactive, phase_c_reactive};
    assign appr_v  = '{phase_a_apparent, phase_b_apparent, phase_c_apparent};
    assign irms_v  = '{phase_a_irms, phase_b_irms, phase_c_irms};
    assign vrms_v  = '{phase_a_vrms, phase_b_vrms, phase_c_vrms};

    // magnitude, widened by one bit so the most negative value survives
    // plain negation at 24 bits would wrap that value back onto itself
    // absolute codes apply it per phase, before the phase sum
    function automatic logic signed [VW:0] mag(input logic signed [VW-1:0] v);
        logic signed [VW:0] w;
        w = (VW+1)'(v);
        return (w < 0) ? -w : w;
    endfunction

    // one phase's contribution for a source code; reserved codes give zero
    // net codes pass the sign through, so an accumulator may run negative
    // quadrants follow the signs of real (p) and reactive (q) power:
    // I p >= 0, q >= 0; II p < 0, q >= 0; III both < 0; IV p >= 0, q < 0
    // a zero real value counts as delivered, so it never lands in II or III
    function automatic logic signed [VW:0] contrib(
        input logic [4:0]           sel,
        input logic signed [VW-1:0] p,
        input logic signed [VW-1:0] q,
        input logic signed [VW-1:0] s,
        input logic signed [VW-1:0] i,
        input logic signed [VW-1:0] u
    );
        logic signed [VW:0] r;
        r = '0;
        case (sel)
            mpsc_pkg::SRC_NET_REAL:  r = (VW+1)'(p);
            mpsc_pkg::SRC_ABS_REAL:  r = mag(p);
            mpsc_pkg::SRC_NET_REACT: r = (VW+1)'(q);
            mpsc_pkg::SRC_ABS_REACT: r = mag(q);
            mpsc_pkg::SRC_APPARENT:  r = (VW+1)'(s);
            mpsc_pkg::SRC_IRMS:      r = (VW+1)'(i);
            mpsc_pkg::SRC_VRMS:      r = (VW+1)'(u);
            // load and line split real energy by its sign
            mpsc_pkg::SRC_REAL_LOAD: r = (p > 0) ? (VW+1)'(p) : '0;
            mpsc_pkg::SRC_REAL_LINE: r = (p < 0) ? mag(p) : '0;
            // reactive energy by quadrant, taken as a magnitude
            mpsc_pkg::SRC_REACT_Q1:
                r = (p >= 0 && q >= 0) ? mag(q) : '0;
            mpsc_pkg::SRC_REACT_Q2:
                r = (p < 0 && q >= 0) ? mag(q) : '0;
            mpsc_pkg::SRC_REACT_Q3:
                r = (p < 0 && q < 0) ? mag(q) : '0;
            mpsc_pkg::SRC_REACT_Q4:
                r = (p >= 0 && q < 0) ? mag(q) : '0;
            default: r = '0; // reserved codes add nothing
        endcase
        return r;
    endfunction

    // register writes at printed offsets; only the low bits of each width
    // a write lands on the next edge; a read in that cycle sees the old value
    // no byte lanes: each access carries the whole register
    always_comb begin
        cfg_nxt   = cfg_r;
        width_nxt = width_r;
        thr_nxt   = thr_r;
        if (reg_wr) begin
            case (reg_addr)
                mpsc_pkg::FIRST_CFG_OFS:    cfg_nxt[0]   = reg_wdata[7:0];
                mpsc_pkg::SECOND_CFG_OFS:   cfg_nxt[1]   = reg_wdata[7:0];
                mpsc_pkg::FIRST_WIDTH_OFS:  width_nxt[0] = reg_wdata[15:0];
                mpsc_pkg::SECOND_WIDTH_OFS: width_nxt[1] = reg_wdata[15:0];
                mpsc_pkg::FIRST_THR_OFS:    thr_nxt[0]   = reg_wdata;
                mpsc_pkg::SECOND_THR_OFS:   thr_nxt[1]   = reg_wdata;
                default: begin
                    // the configs never share an offset, so no write hits both
                    cfg_nxt = cfg_r; // unmapped writes dropped
                end
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    // the result holds between reads so a slow master may fetch it late
    // reads have no side effects on any register
    always_comb begin
        rdata_nxt = reg_rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                mpsc_pkg::FIRST_CFG_OFS:    rdata_nxt = {24'h000000, cfg_r[0]};
                mpsc_pkg::SECOND_CFG_OFS:   rdata_nxt = {24'h000000, cfg_r[1]};
                mpsc_pkg::FIRST_WIDTH_OFS:  rdata_nxt = {16'h0000, width_r[0]};
                mpsc_pkg::SECOND_WIDTH_OFS: rdata_nxt = {16'h0000, width_r[1]};
                mpsc_pkg::FIRST_THR_OFS:    rdata_nxt = thr_r[0];
                mpsc_pkg::SECOND_THR_OFS:   rdata_nxt = thr_r[1];
                default:                    rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // register file
    // the read register clears too, so the bus reads zero until the first read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // both outputs share one reset image
            for (int k = 0; k < 2; k++) begin
                cfg_r[k]   <= mpsc_pkg::CFG_RESET;
                width_r[k] <= mpsc_pkg::WIDTH_RESET;
                thr_r[k]   <= mpsc_pkg::THR_RESET;
            end
            reg_rdata_r <= 32'h00000000;
        end else begin
            cfg_r       <= cfg_nxt;
            width_r     <= width_nxt;
            thr_r       <= thr_nxt;
            reg_rdata_r <= rdata_nxt;
        end
    end

    // per output: select quantity, gate phases, sum, drive a pulse engine
    // trade-off: an adder chain per output instead of a shared one, so both
    // outputs update in the same frame without arbitration
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic [4:0]           sel;
        logic signed [IW-1:0] inc;
        // quantity code, one coding for both outputs
        assign sel = cfg_r[ch][mpsc_pkg::SEL_HI:mpsc_pkg::SEL_LO];

        // each output reads only its own config, so they never interact
        always_comb begin
            inc = '0;
            // a cleared phase bit adds nothing, as if the phase were dead
            for (int ph = 0; ph < 3; ph++) begin
                if (cfg_r[ch][ph]) begin
                    inc = inc + IW'(contrib(sel, real_v[ph], react_v[ph],
                                            appr_v[ph], irms_v[ph],
                                            vrms_v[ph]));
                end
            end
        end

        // threshold compare, remainder and width count live in the channel
        mpsc_pulse_chan u_chan (
            .ref_clk     (ref_clk),
            .rst         (rst),
            .frame_tick  (frame_tick),
            .increment   (inc),
            .threshold   (thr_r[ch]),
            .pulse_width (width_r[ch]),
            .pulse_out_r (pulse_w[ch])
        );
    end

    // outputs come from the channel flip-flops directly
    // no extra stage here: a second flop would add a cycle to every pulse
    assign first_pulse_output  = pulse_w[0];
    assign second_pulse_output = pulse_w[1];
endmodule // mpsc_top

// ==== tb/mpsc_chk.sv ====
`timescale 1ns/100ps
// watches the top ports: read path and pulse timing against frame_tick
module mpsc_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [11:0] reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_r,
    input wire logic        frame_tick,
    input wire logic        first_pulse_output,
    input wire logic        second_pulse_output
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic mapped;
    // every offset the block decodes; anything else reads as zero
    assign mapped = reg_addr inside {12'h01E, 12'h01F, 12'h020, 12'h022,
                                     12'h026, 12'h028};
    chk_reset_quiet:
    assert property (disable iff (1'b0) rst |=> !first_pulse_output &&
        !second_pulse_output && reg_rdata_r == 32'h0)
        else $error("outputs busy after reset");
    chk_unmapped_zero:
    assert property (reg_rd && !mapped |-> ##[1:2] reg_rdata_r == 32'h0)
        else $error("unmapped read not zero");
    chk_cfg_byte_only:
    assert property (reg_rd && reg_addr inside {12'h01E, 12'h01F}
        |-> ##[1:2] reg_rdata_r[31:8] == 24'h0)
        else $error("config read wider than a byte");
    chk_rdata_holds:
    assert property (!reg_rd && !$past(reg_rd) |=> $stable(reg_rdata_r))
        else $error("read data moved without a read");
    chk_first_rise:
    assert property ($rose(first_pulse_output)
        |-> $past(frame_tick) || $past(frame_tick, 2))
        else $error("first pulse rose off frame");
    chk_second_rise:
    assert property ($rose(second_pulse_output)
        |-> $past(frame_tick) || $past(frame_tick, 2))
        else $error("second pulse rose off frame");
    chk_first_fall:
    assert property ($fell(first_pulse_output)
        |-> $past(frame_tick) || $past(frame_tick, 2))
        else $error("first pulse fell off frame");
    chk_second_fall:
    assert property ($fell(second_pulse_output)
        |-> $past(frame_tick) || $past(frame_tick, 2))
        else $error("second pulse fell off frame");
    cov_first: cover property ($rose(first_pulse_output));
    cov_second: cover property ($rose(second_pulse_output));
    cov_unmapped: cover property (reg_rd && !mapped);
endmodule // mpsc_chk

// ==== tb/mpsc_counter.sv ====
`timescale 1ns/100ps
// meter test equipment: counts pulses, blind to their width
module mpsc_counter (
    input  wire logic ref_clk,
    input  wire logic first_pulse_output,
    input  wire logic second_pulse_output,
    output int        first_count,
    output int        second_count
);
    logic first_d_r = 1'b0;
    logic second_d_r = 1'b0;
    initial first_count = 0;
    initial second_count = 0;
    // one count per rising edge, so an extended pulse counts once
    always @(posedge ref_clk) begin
        first_d_r <= first_pulse_output;
        second_d_r <= second_pulse_output;
        if (first_pulse_output && !first_d_r) first_count <= first_count + 1;
        if (second_pulse_output && !second_d_r)
            second_count <= second_count + 1;
    end
endmodule // mpsc_counter

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        frame_tick = 1'b0;
    logic [31:0] reg_rdata_r;
    logic [31:0] d;
    logic        first_pulse_output;
    logic        second_pulse_output;
    logic signed [mpsc_pkg::VAL_W-1:0] v [15];
    logic [7:0]  cfg [2];
    longint      acc [2];
    longint      thr [2];
    int          wd [2];
    int          wcnt [2];
    int          fired [2];
    int          n1;
    int          n2;
    int          failures = 0;
    int          checks_done = 0;
    always #5 ref_clk = ~ref_clk;
    mpsc_top uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .frame_tick(frame_tick),
        .phase_a_real(v[0]), .phase_a_reactive(v[1]),
        .phase_a_apparent(v[2]), .phase_a_irms(v[3]), .phase_a_vrms(v[4]),
        .phase_b_real(v[5]), .phase_b_reactive(v[6]),
        .phase_b_apparent(v[7]), .phase_b_irms(v[8]), .phase_b_vrms(v[9]),
        .phase_c_real(v[10]), .phase_c_reactive(v[11]),
        .phase_c_apparent(v[12]), .phase_c_irms(v[13]),
        .phase_c_vrms(v[14]), .first_pulse_output(first_pulse_output),
        .second_pulse_output(second_pulse_output));
    mpsc_counter meter (.ref_clk(ref_clk),
        .first_pulse_output(first_pulse_output),
        .second_pulse_output(second_pulse_output),
        .first_count(n1), .second_count(n2));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] x);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = x;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    // read data is taken two edges on, where both latencies have settled
    task automatic rd(input logic [11:0] a, output logic [31:0] x);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        @(negedge ref_clk);
        x = reg_rdata_r;
    endtask
    function automatic longint inc(input logic [4:0] c,
                                   input longint p, q, s, i, u);
        case (c)
            5'h00: return p;
            5'h01: return p < 0 ? -p : p;
            5'h02: return q;
            5'h03: return q < 0 ? -q : q;
            5'h04: return s;
            5'h06: return i;
            5'h07: return u;
            5'h08: return p > 0 ? p : 0;
            5'h09: return p < 0 ? -p : 0;
            5'h0A: return (p >= 0 && q >= 0) ? q : 0;
            5'h0B: return (p < 0 && q >= 0) ? q : 0;
            5'h0C: return (p < 0 && q < 0) ? -q : 0;
            5'h0D: return (p >= 0 && q < 0) ? -q : 0;
            default: return 0;
        endcase
    endfunction
    // one converter frame with fresh random phase values
    task automatic frame();
        int b;
        int prev;
        @(negedge ref_clk);
        foreach (v[k]) v[k] = 24'($urandom);
        frame_tick = 1'b1;
        for (int ch = 0; ch < 2; ch++) begin
            for (int ph = 0; ph < 3; ph++) begin
                b = ph * 5;
                if (cfg[ch][ph]) acc[ch] += inc(cfg[ch][7:3], v[b],
                    v[b + 1], v[b + 2], v[b + 3], v[b + 4]);
            end
            // width counts down every frame; a crossing restarts it
            prev = wcnt[ch];
            if (wcnt[ch] > 0) wcnt[ch]--;
            if (acc[ch] > thr[ch]) begin
                acc[ch] -= thr[ch];
                if (wd[ch] > 0) begin
                    if (prev == 0) fired[ch]++;
                    wcnt[ch] = wd[ch];
                end
            end
        end
        @(negedge ref_clk);
        frame_tick = 1'b0;
        @(negedge ref_clk);
        chk(first_pulse_output, wcnt[0] > 0);
        chk(second_pulse_output, wcnt[1] > 0);
    endtask
    task automatic setup(input int ch, input logic [7:0] c,
                         input logic [31:0] t, input logic [15:0] w);
        wr(ch ? 12'h01F : 12'h01E, {24'h0, c});
        wr(ch ? 12'h028 : 12'h022, t);
        wr(ch ? 12'h026 : 12'h020, {16'h0, w});
        cfg[ch] = c;
        thr[ch] = t;
        wd[ch] = w;
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #300000;
        failures++;
        $display("watchdog expired");
        results();
    end
    initial begin
        logic [31:0] x;
        logic [31:0] y;
        foreach (v[k]) v[k] = '0;
        for (int ch = 0; ch < 2; ch++) begin
            cfg[ch] = mpsc_pkg::CFG_RESET;
            thr[ch] = mpsc_pkg::THR_RESET;
            wd[ch] = mpsc_pkg::WIDTH_RESET;
            acc[ch] = 0;
            wcnt[ch] = 0;
            fired[ch] = 0;
        end
        void'($urandom(32'h4CD6));
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        rd(12'h01E, d); chk(d, 32'h0);
        rd(12'h01F, d); chk(d, 32'h0);
        rd(12'h020, d); chk(d, 32'h9C);
        rd(12'h022, d); chk(d, mpsc_pkg::THR_RESET);
        rd(12'h026, d); chk(d, 32'h9C);
        rd(12'h028, d); chk(d, mpsc_pkg::THR_RESET);
        rd(12'h006, d); chk(d, 32'h0);
        repeat (3) frame();
        $display("reset values and idle frames done");
        x = $urandom;
        y = $urandom;
        x[7:3] = 5'($urandom_range(0, 4));
        y[7:3] = 5'($urandom_range(8, 13));
        wr(12'h01E, x);
        wr(12'h01F, y);
        rd(12'h01E, d); chk(d, {24'h0, x[7:0]});
        rd(12'h01F, d); chk(d, {24'h0, y[7:0]});
        $display("independent config registers done");
        for (int c = 0; c < 14; c++) begin
            if (c == 5) continue;
            setup(0, {5'(c), 3'($urandom_range(1, 7))},
                  $urandom_range(32'h1000, 32'h400000), $urandom_range(0, 3));
            setup(1, {5'(c == 8 ? 8 : 13 - c), 3'($urandom_range(1, 7))},
                  $urandom_range(32'h1000, 32'h400000), $urandom_range(0, 3));
            rd(12'h01E, d); chk(d, {24'h0, cfg[0]});
            rd(12'h01F, d); chk(d, {24'h0, cfg[1]});
            repeat (5) frame();
        end
        chk(n1, fired[0]);
        chk(n2, fired[1]);
        $display("source codes and phase masks done");
        results();
    end
endmodule // tb_top
bind mpsc_top mpsc_chk chk_i (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .frame_tick(frame_tick), .first_pulse_output(first_pulse_output),
    .second_pulse_output(second_pulse_output));
